// ==== logic/amp_fault_latch_clear.sv ====
/*
 * Fault detection, latching and clearing for an on-board servo amplifier,
 * external-drive signal breakout and analog sample readout.
 * Assumes sensors and pins arrive asynchronously; sampled ADC codes come from
 * a converter front end on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1 - Averaged temperature above 110 C sets over-temperature fault, disables amplifier.
// R2 - Over-temperature clear refused until temperature is below 80 C.
// R3 - Over-temperature fault stays latched until the clear sequence.
// R4 - Supply under rated level sets under-voltage fault, disables amplifier.
// R5 - Under-voltage clear refused while supply is still low.
// R6 - Under-voltage non-latching by default; latch config argument 2 makes it latch.
// R7 - Abort with cutoff jumper fitted disables power stage, latches cutoff fault.
// R8 - All axes idle and nothing latched: report shows live fault state.
// R9 - A fault latches for a bank only if an axis there holds servo.
// R10 - Axes idle then latch config argument 1 releases the latches.
// R11 - Host halts moving axes before clearing faults.
// R12 - After a clear, report shows faults still physically present.
// R13 - Per axis jumper routes step/dir or enable/command onto shared pins.
// R14 - No jumper fitted leaves that axis's pins undriven.
// R15 - Eight bipolar inputs digitised with 12 bits over -10 V to 10 V.
// R16 - Each converted input readable at an offset indexed by input number.
// R17 - Report gives an eight-bit fault mask plus latched flags per bank.
// R18 - Each fault type has a fixed bit in the report mask.
module amp_fault_latch_clear #(
  parameter int axes     = 8,
  parameter int adc_bits = 12
) (
  // Clock and reset
  input  wire logic                               sys_clk,
  input  wire logic                               reset_n,
  // Avalon-MM slave
  input  wire logic [5:0]                         address,
  input  wire logic                               read,
  input  wire logic                               write,
  input  wire logic [31:0]                        writedata,
  input  wire logic [3:0]                         byteenable,
  output logic      [31:0]                        readdata,
  output logic                                    waitrequest,
  output logic                                    irq,
  // Sensors, asynchronous
  input  wire logic [7:0]                         temp_avg,
  input  wire logic                               supply_low,
  input  wire logic                               abort_in,
  input  wire logic                               cutoff_jumper,
  // Converter samples, same clock
  input  wire logic [7:0][adc_bits-1:0]           adc_sample,
  // Per-axis step/dir and enable/command sources
  input  wire amp_fault_pkg::ext_pins_s [axes-1:0] step_dir,
  input  wire amp_fault_pkg::ext_pins_s [axes-1:0] en_cmd,
  // Shared external connector pins, oe low while driven
  output amp_fault_pkg::ext_pins_s [axes-1:0]     ext_out,
  output logic      [axes-1:0]                    ext_oe_n,
  // Amplifier power stage
  output logic                                    amp_enable
);

  // Every bus access takes one wait cycle: the request is seen in its first
  // cycle, read data is loaded at the end of it, and the request is taken at
  // the following edge, where waitrequest is low. Sensors are asynchronous
  // and reach the fault logic a few cycles late. That is harmless against
  // thermal and supply events but sets the reaction time of the stage cutoff.

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  logic [9:0] sync1_q;
  logic [9:0] sync2_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 10'h000;
      sync2_q <= 10'h000;
    end else begin
      sync1_q <= {cutoff_jumper, abort_in, temp_avg};
      sync2_q <= sync1_q;
    end
  end
  // A multi-bit temperature code may change bit by bit across the clock
  // boundary, so it is only trusted when two synchronised samples agree.
  // The extra stage costs one cycle of latency but keeps the first flop
  // read by the second one alone.
  logic [7:0] temp_s3_q;
  logic [7:0] temp_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      temp_s3_q <= 8'h00;
    end else begin
      temp_s3_q <= sync2_q[7:0];
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      temp_q <= 8'h00;
    end else if (sync2_q[7:0] == temp_s3_q) begin
      temp_q <= sync2_q[7:0];
    end
  end
  logic uv_s1_q;
  logic uv_s2_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      uv_s1_q <= 1'b0;
      uv_s2_q <= 1'b0;
    end else begin
      uv_s1_q <= supply_low;
      uv_s2_q <= uv_s1_q;
    end
  end
  wire abort_s  = sync2_q[8];
  wire jumper_s = sync2_q[9];

  ////////////////////////////////////////////////////////////////////////////
  // Software registers and bus decode.

  logic [2*axes-1:0] axis_state_q;
  logic [2*axes-1:0] jumper_q;
  logic [2:0]        mask_q;
  logic              uv_latching_q;
  logic              ack_q;

  // Writes land only at the edge where waitrequest is sampled low, so a held
  // request never applies twice. The status clear happens at the edge that
  // captures read data, so an event arriving after it is never lost.
  wire bus_take  = ack_q;
  wire wr_axis   = write && bus_take && (address == amp_fault_pkg::reg_axis);
  wire wr_jumper = write && bus_take && (address == amp_fault_pkg::reg_jumper);
  wire wr_mask   = write && bus_take && (address == amp_fault_pkg::reg_irq_mask);
  wire wr_cmd    = write && bus_take && (address == amp_fault_pkg::reg_command)
                 && byteenable[0];
  wire rd_stat   = read && !ack_q && (address == amp_fault_pkg::reg_irq_stat);
  wire [1:0] cmd_arg = writedata[1:0];

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      axis_state_q  <= '0;
      jumper_q      <= '0;
      mask_q        <= amp_fault_pkg::mask_rst;
      uv_latching_q <= 1'b0;
    end else begin
      if (wr_axis) begin
        axis_state_q <= writedata[2*axes-1:0];
      end
      if (wr_jumper) begin
        jumper_q <= writedata[2*axes-1:0];
      end
      if (wr_mask) begin
        mask_q <= writedata[2:0];
      end
      // Latching of under-voltage is one-way: only reset turns it off.
      if (wr_cmd && cmd_arg == amp_fault_pkg::arg_uv_lat) begin
        uv_latching_q <= 1'b1; // R6
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Axis state summary per bank.

  logic [axes-1:0] idle_v;
  logic [axes-1:0] hold_v;
  genvar g;
  generate
    for (g = 0; g < axes; g++) begin : g_axis
      wire amp_fault_pkg::axis_e st = amp_fault_pkg::axis_e'(axis_state_q[2*g+1:2*g]);
      assign idle_v[g] = (st == amp_fault_pkg::drive_idle_state);
      assign hold_v[g] = (st == amp_fault_pkg::servo_hold_state);
    end
  endgenerate
  wire all_idle   = &idle_v;
  wire bank0_hold = |hold_v[axes/2-1:0];      // R9
  wire bank1_hold = |hold_v[axes-1:axes/2];   // R9

  ////////////////////////////////////////////////////////////////////////////
  // Live conditions and latches.

  // Over-temperature has hysteresis: set above upper, released below lower.
  logic ot_live_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ot_live_q <= 1'b0;
    end else if (temp_q > amp_fault_pkg::temp_upper) begin
      ot_live_q <= 1'b1; // R1
    end else if (temp_q < amp_fault_pkg::temp_lower) begin
      ot_live_q <= 1'b0; // R2
    end
  end
  wire uv_live = uv_s2_q;
  wire co_live = abort_s && jumper_s;
  wire [2:0] live = {co_live, uv_live, ot_live_q}; // R18

  wire       latchable = (bank0_hold || bank1_hold);
  wire [2:0] lat_en    = {1'b1, uv_latching_q, 1'b1};
  wire       clear_req = wr_cmd && cmd_arg == amp_fault_pkg::arg_clear && all_idle; // R10

  // A bank flag records which bank held servo when a fault latched, so the
  // host can tell which group of axes was affected. Both the latches and the
  // flags drop together on an accepted clear.
  logic [2:0] latch_q;
  logic [1:0] bank_q;
  // A clear drops a fault that is still present; live re-sets it only once an axis holds servo again.
  wire [2:0] latch_d = (clear_req ? 3'h0 : latch_q)
                     | (latchable ? (live & lat_en) : 3'h0); // R3 R5 R7
  wire [1:0] bank_d  = (clear_req ? 2'h0 : bank_q)
                     | ({bank1_hold, bank0_hold} & {2{|(live & lat_en)}}); // R9
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_q <= 3'h0;
      bank_q  <= 2'h0;
    end else begin
      latch_q <= latch_d;
      bank_q  <= bank_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Amplifier power stage.

  // Nonlatching under-voltage and live faults still disable the stage.
  wire [2:0] fault_now = latch_q | live;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      amp_enable <= 1'b0;
    end else begin
      amp_enable <= ~|fault_now; // R1 R4 R7
    end
  end

  // Report: live state when idle and unlatched, else latched plus live.
  wire [7:0] report_mask = (all_idle && latch_q == 3'h0) ? {5'h00, live} // R8
                         : {5'h00, fault_now}; // R12 R17

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: fault events, cleared by a read; a new event wins.

  logic [2:0] live_prev_q;
  logic [2:0] irq_stat_q;
  wire  [2:0] rise = live & ~live_prev_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      live_prev_q <= 3'h0;
      irq_stat_q  <= 3'h0;
    end else begin
      live_prev_q <= live;
      irq_stat_q  <= (rd_stat ? 3'h0 : irq_stat_q) | rise;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External-drive breakout: jumper 01 step/dir, 10 enable/command, 00 none.

  generate
    for (g = 0; g < axes; g++) begin : g_ext
      wire [1:0] sel      = jumper_q[2*g+1:2*g];
      // An undecoded selection leaves the pins released, never half driven.
      wire       drive_on = (sel == 2'b01) || (sel == 2'b10);
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          ext_out[g]  <= '0;
          ext_oe_n[g] <= 1'b1;
        end else begin
          ext_out[g]  <= sel[1] ? en_cmd[g] : step_dir[g]; // R13
          ext_oe_n[g] <= ~drive_on;                         // R14
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; one-cycle answer, so waitrequest is high on the first cycle.

  wire req = (read || write) && !ack_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end
  assign waitrequest = req;

  wire [2:0]  adc_idx  = address[4:2];
  wire        is_adc   = address[5];  // R16
  // Bipolar codes are sign-extended so software reads a signed voltage.
  wire [31:0] adc_word = {{(32-adc_bits){adc_sample[adc_idx][adc_bits-1]}},
                          adc_sample[adc_idx]}; // R15
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (is_adc) begin
      rd_mux = adc_word; // R16
    end else if (address == amp_fault_pkg::reg_report) begin
      rd_mux = {22'h0, bank_q, report_mask}; // R17
    end else if (address == amp_fault_pkg::reg_command) begin
      rd_mux = {31'h0, uv_latching_q};
    end else if (address == amp_fault_pkg::reg_axis) begin
      rd_mux = 32'(axis_state_q);
    end else if (address == amp_fault_pkg::reg_jumper) begin
      rd_mux = 32'(jumper_q);
    end else if (address == amp_fault_pkg::reg_irq_stat) begin
      rd_mux = {29'h0, irq_stat_q};
    end else if (address == amp_fault_pkg::reg_irq_mask) begin
      rd_mux = {29'h0, mask_q};
    end
  end

  // Read data is loaded in the wait cycle and stands until the next read.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= 32'h0;
    end else if (read && !ack_q) begin
      readdata <= rd_mux;
    end
  end

endmodule // amp_fault_latch_clear
`default_nettype wire

// ==== shared/amp_fault_pkg.sv ====
/*
 * Constants, register map and carrier types for the amplifier fault block.
 * Assumes a 32-bit Avalon-MM register bus on a single 200 MHz clock.
 */
package amp_fault_pkg;
  // Register byte offsets.
  localparam logic [5:0] reg_report   = 6'h00;
  localparam logic [5:0] reg_command  = 6'h04;
  localparam logic [5:0] reg_axis     = 6'h08;
  localparam logic [5:0] reg_jumper   = 6'h0c;
  localparam logic [5:0] reg_irq_stat = 6'h10;
  localparam logic [5:0] reg_irq_mask = 6'h14;
  localparam logic [5:0] reg_adc_base = 6'h20;
  // Fault bit positions in the report bitmask.
  localparam int bit_over_temp  = 0;
  localparam int bit_under_volt = 1;
  localparam int bit_cutoff     = 2;
  localparam int rep_bank0      = 8;
  localparam int rep_bank1      = 9;
  // Temperature thresholds, degrees C, eight-bit code.
  localparam logic [7:0] temp_upper = 8'd110;
  localparam logic [7:0] temp_lower = 8'd80;
  // Fault latch configuration arguments.
  localparam logic [1:0] arg_clear  = 2'd1;
  localparam logic [1:0] arg_uv_lat = 2'd2;
  // Reset values.
  localparam logic [7:0] jumper_rst = 8'h00;
  localparam logic [2:0] mask_rst   = 3'h0;
  // Per-axis drive states.
  typedef enum logic [1:0] {drive_idle_state, servo_hold_state, axis_moving} axis_e;
  // Pins of one external-drive breakout axis.
  typedef struct packed {
    logic pin_a;
    logic pin_b;
  } ext_pins_s;
endpackage

// ==== tb/amp_fault_props.sv ====
/* Checker on the fault block's ports.
   Assumes sensor inputs are held for several cycles. */
`timescale 1ns/1ps
`default_nettype none
module amp_fault_props #(parameter int axes = 8) (
  // Clock, reset and bus
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Sensors, pins and power stage
  input wire logic [7:0] temp_avg,
  input wire logic supply_low,
  input wire logic abort_in,
  input wire logic cutoff_jumper,
  input wire amp_fault_pkg::ext_pins_s [axes-1:0] step_dir,
  input wire amp_fault_pkg::ext_pins_s [axes-1:0] en_cmd,
  input wire amp_fault_pkg::ext_pins_s [axes-1:0] ext_out,
  input wire logic [axes-1:0] ext_oe_n,
  input wire logic amp_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Every access costs exactly one wait cycle.
  sequence one_wait;
    waitrequest ##1 !waitrequest;
  endsequence
  a_read_wait: assert property ($rose(read) |-> one_wait)
    else $error("read wait wrong");
  a_write_wait: assert property ($rose(write) |-> one_wait)
    else $error("write wait wrong");
  a_idle_nowait: assert property (!read && !write |-> !waitrequest)
    else $error("wait without request");
  a_data_hold: assert property (!read |=> $stable(readdata))
    else $error("read data moved");
  a_hot_off: assert property ((temp_avg > amp_fault_pkg::temp_upper)[*7] |-> !amp_enable)
    else $error("hot amplifier enabled");
  a_low_off: assert property (supply_low[*6] |-> !amp_enable)
    else $error("low supply amplifier enabled");
  a_cut_off: assert property ((abort_in && cutoff_jumper)[*6] |-> !amp_enable)
    else $error("abort amplifier enabled");
  a_pin_route: assert property (!ext_oe_n[0] |->
    ext_out[0] == $past(step_dir[0]) || ext_out[0] == $past(en_cmd[0]))
    else $error("pin source wrong");
endmodule // amp_fault_props
bind amp_fault_latch_clear amp_fault_props #(.axes(axes)) props_inst (.sys_clk, .reset_n,
  .read, .write, .readdata, .waitrequest, .temp_avg, .supply_low, .abort_in,
  .cutoff_jumper, .step_dir, .en_cmd, .ext_out, .ext_oe_n, .amp_enable);
`default_nettype wire

// ==== tb/amp_host.sv ====
/* Host model: Avalon-MM master with access and clear tasks.
   Assumes the slave answers on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module amp_host (
  // Clock
  input  wire logic        sys_clk,
  // Avalon-MM master
  input  wire logic        waitrequest,
  input  wire logic [31:0] readdata,
  output logic      [5:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  output logic      [3:0]  byteenable
);
  initial begin
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hf;
  end
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    do @(posedge sys_clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // Axes are stopped and idled first, else the release is refused.
  task automatic clear_faults();
    logic [31:0] q;
    bus(1'b1, amp_fault_pkg::reg_axis, 32'h0, q);
    bus(1'b1, amp_fault_pkg::reg_command, 32'h1, q);
  endtask
endmodule // amp_host
`default_nettype wire

// ==== tb/tb_amp_fault_latch_clear.sv ====
/* Self-checking bench for the fault block.
   Assumes the host model makes all bus traffic. */
`timescale 1ns/1ps
`default_nettype none
module tb_amp_fault_latch_clear;
  logic sys_clk = 1'b0, reset_n = 1'b0, read, write, waitrequest, irq, amp_enable;
  logic [5:0] address;
  logic [31:0] readdata, writedata;
  logic [3:0] byteenable;
  logic [7:0] temp_avg = 8'd25, ext_oe_n;
  logic supply_low = 1'b0, abort_in = 1'b0, cutoff_jumper = 1'b0;
  logic [7:0][11:0] adc_sample = '0;
  amp_fault_pkg::ext_pins_s [7:0] step_dir = '0, en_cmd = '0, ext_out;
  int errors = 0, compares = 0, cyc = 0;
  amp_host amp_host_inst (.sys_clk, .waitrequest, .readdata, .address, .read, .write,
    .writedata, .byteenable);
  amp_fault_latch_clear amp_fault_latch_clear_inst (.sys_clk, .reset_n, .address, .read,
    .write, .writedata, .byteenable, .readdata, .waitrequest, .irq, .temp_avg, .supply_low,
    .abort_in, .cutoff_jumper, .adc_sample, .step_dir, .en_cmd, .ext_out, .ext_oe_n,
    .amp_enable);
  initial forever #2.5 sys_clk = !sys_clk;
  task automatic give_verdict();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    amp_host_inst.bus(1'b0, a, 32'h0, q);
    cmp(q & m, e);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    amp_host_inst.bus(1'b1, a, d, q);
  endtask
  // Sensor inputs pass two or three synchroniser stages.
  task automatic settle();
    repeat (8) @(posedge sys_clk);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    chk(amp_fault_pkg::reg_report, 32'h3ff, 32'h0);
    chk(amp_fault_pkg::reg_command, 32'h1, 32'h0);
    chk(amp_fault_pkg::reg_jumper, 32'hffff, 32'h0);
    chk(6'h3c, 32'hffffffff, 32'h0);
    cmp(ext_oe_n, 8'hff);
    @(posedge sys_clk) supply_low <= 1'b1;
    settle();
    cmp(irq, 1'b0);
    chk(amp_fault_pkg::reg_report, 32'h3ff, 32'h2);
    cmp(amp_enable, 1'b0);
    wr(amp_fault_pkg::reg_irq_mask, 32'h7);
    settle();
    cmp(irq, 1'b1);
    chk(amp_fault_pkg::reg_irq_stat, 32'h7, 32'h2);
    chk(amp_fault_pkg::reg_irq_stat, 32'h7, 32'h0);
    cmp(irq, 1'b0);
    @(posedge sys_clk) supply_low <= 1'b0;
    settle();
    chk(amp_fault_pkg::reg_report, 32'h3ff, 32'h0);
    @(posedge sys_clk) temp_avg <= 8'd111;
    settle();
    chk(amp_fault_pkg::reg_report, 32'h3ff, 32'h1);
    wr(amp_fault_pkg::reg_axis, 32'h1);
    settle();
    chk(amp_fault_pkg::reg_report, 32'h3ff, 32'h101);
    cmp(amp_enable, 1'b0);
    @(posedge sys_clk) temp_avg <= 8'd80;
    settle();
    chk(amp_fault_pkg::reg_report, 32'hff, 32'h1);
    amp_host_inst.clear_faults();
    chk(amp_fault_pkg::reg_report, 32'hff, 32'h1);
    @(posedge sys_clk) temp_avg <= 8'd79;
    settle();
    amp_host_inst.clear_faults();
    chk(amp_fault_pkg::reg_report, 32'h3ff, 32'h0);
    wr(amp_fault_pkg::reg_command, 32'h2);
    chk(amp_fault_pkg::reg_command, 32'h1, 32'h1);
    wr(amp_fault_pkg::reg_axis, 32'h100);
    @(posedge sys_clk) supply_low <= 1'b1;
    settle();
    @(posedge sys_clk) supply_low <= 1'b0;
    settle();
    chk(amp_fault_pkg::reg_report, 32'h3ff, 32'h202);
    amp_host_inst.clear_faults();
    chk(amp_fault_pkg::reg_report, 32'h3ff, 32'h0);
    wr(amp_fault_pkg::reg_axis, 32'h1);
    @(posedge sys_clk) abort_in <= 1'b1;
    cutoff_jumper <= 1'b1;
    settle();
    @(posedge sys_clk) abort_in <= 1'b0;
    settle();
    chk(amp_fault_pkg::reg_report, 32'h3ff, 32'h104);
    cmp(amp_enable, 1'b0);
    amp_host_inst.clear_faults();
    chk(amp_fault_pkg::reg_report, 32'h3ff, 32'h0);
    cmp(amp_enable, 1'b1);
    step_dir <= 16'he4e4;
    en_cmd <= 16'h1b1b;
    for (int n = 0; n < 8; n++) adc_sample[n] <= 12'h800 - 12'(n);
    wr(amp_fault_pkg::reg_jumper, 32'h39);
    settle();
    cmp(ext_oe_n, 8'hfc);
    cmp({ext_out[1], ext_out[0]}, 4'h8);
    for (int n = 0; n < 8; n++)
      chk(amp_fault_pkg::reg_adc_base + 6'(4 * n), 32'hffffffff,
          {{20{n == 0}}, 12'h800 - 12'(n)});
    give_verdict();
  end
endmodule // tb_amp_fault_latch_clear
`default_nettype wire
